// File: pkg/boot_regs_pkg.sv
// boot status and output register slice: shared constants and carriers
// assumes a byte-wide register port behind the serial interface decoder
package boot_regs_pkg;

  // register offsets
  localparam logic [7:0] OFS_BOOT_STATUS = 8'h00;
  localparam logic [7:0] OFS_TEMP_RESULT = 8'h01;
  localparam logic [7:0] OFS_MAG_LOW     = 8'h02;
  localparam logic [7:0] OFS_MAG_HIGH    = 8'h03;

  // field positions
  localparam int BOOT_FLAG_BIT = 0;

  // reset values
  localparam logic [7:0]  MAG_LOW_RESET   = 8'h00;
  localparam logic [7:0]  MAG_HIGH_RESET  = 8'h00;
  localparam logic [7:0]  TEMP_RESET      = 8'h00;
  localparam logic [11:0] MAG_VALUE_RESET = 12'h000;

  // boot pulse timing (clock 100 MHz)
  localparam int CLK_MHZ            = 100;
  localparam int BOOT_SHORT_US      = 1;
  localparam int BOOT_LONG_MS       = 1;
  localparam int BOOT_SHORT_CYCLES  = BOOT_SHORT_US * CLK_MHZ;
  localparam int BOOT_LONG_CYCLES   = BOOT_LONG_MS * 1000 * CLK_MHZ;

  // interrupt pin settings kept across soft reset
  typedef struct packed {
    logic polarity_high;
    logic open_drain;
    logic route_line_two;
  } irq_setup_t;

  // interrupt pin setup after power-on or hibernate exit
  localparam irq_setup_t IRQ_SETUP_RESET = '{polarity_high: 1'b1, open_drain: 1'b0, route_line_two: 1'b0};

  // result sample from the datapaths
  typedef struct packed {
    logic        sample_valid;
    logic [7:0]  temperature;
    logic [11:0] magnitude;
  } result_sample_t;

  // host register access
  typedef struct packed {
    logic       read_strobe;
    logic       write_strobe;
    logic [7:0] address;
    logic [7:0] write_data;
  } reg_access_t;

endpackage : boot_regs_pkg

// File: core/boot_pulse_timer.sv
// one-shot pulse timer for the boot event output
// assumes start is a single-cycle pulse on clk_sys_i
module boot_pulse_timer #(
  parameter int WIDTH_BITS = 24
) (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rstn_i,
  // control
  input  wire logic                  start_i,
  input  wire logic [WIDTH_BITS-1:0] length_i,
  // status
  output logic                       active_o
);

  logic [WIDTH_BITS-1:0] remaining;
  wire                   last_cycle = (remaining == WIDTH_BITS'(1));
  wire [WIDTH_BITS-1:0]  next_remaining = start_i ? length_i :
                                          (remaining != '0) ? remaining - WIDTH_BITS'(1) : remaining;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      remaining <= '0;
      active_o  <= 1'b0;
    end else begin
      remaining <= next_remaining;
      active_o  <= start_i | ((remaining != '0) & ~last_cycle);
    end
  end

endmodule : boot_pulse_timer

// File: core/boot_status_and_output_regs.sv
// boot flag, boot pulse pins, temperature and vector magnitude registers
// assumes serial decoder gives one-cycle strobes; results arrive as samples
module boot_status_and_output_regs #(
  parameter int SHORT_CYCLES = boot_regs_pkg::BOOT_SHORT_CYCLES,
  parameter int LONG_CYCLES  = boot_regs_pkg::BOOT_LONG_CYCLES,
  parameter int TIMER_BITS   = 24
) (
  // clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          rstn_i,
  // boot sequencing
  input  wire logic                          soft_reset_i,
  input  wire logic                          hibernate_exit_i,
  input  wire logic                          boot_finished_i,
  input  wire logic                          boot_mode_strap_i,
  input  wire logic                          boot_irq_enable_i,
  // interrupt pin setup writes
  input  wire logic                          setup_write_i,
  input  wire boot_regs_pkg::irq_setup_t     setup_data_i,
  // datapath inputs
  input  wire boot_regs_pkg::result_sample_t sample_i,
  input  wire logic                          magnitude_calc_enable_i,
  input  wire logic                          byte_order_select_i,
  // host register port
  input  wire boot_regs_pkg::reg_access_t    access_i,
  // host answers
  output logic [7:0]                         read_data_o,
  output logic                               read_valid_o,
  output logic                               access_refused_o,
  output logic                               data_ready_clear_o,
  output logic                               boot_done_flag_o,
  // interrupt pins
  output logic                               irq_line_one_o,
  output logic                               irq_line_one_oe_n_o,
  output logic                               irq_line_two_o,
  output logic                               irq_line_two_oe_n_o
);

  logic                      boot_done_flag;
  logic                      boot_seen;
  boot_regs_pkg::irq_setup_t irq_setup;
  logic                      strap_low;
  logic [7:0]                temperature_result;
  logic [11:0]               vector_magnitude;
  logic                      pulse_long;
  logic                      pulse_on_two;
  logic                      pulse_pol_high;
  logic                      pulse_open_drain;
  logic                      pulse_active;

  // flag clears on soft reset or hibernate exit
  wire flag_clear  = soft_reset_i | hibernate_exit_i;
  wire boot_event  = boot_finished_i & ~boot_seen & ~flag_clear;
  wire access_ok   = boot_done_flag;
  wire any_access  = access_i.read_strobe | access_i.write_strobe;
  wire read_ok     = access_i.read_strobe & access_ok;
  wire setup_take  = setup_write_i & access_ok;

  // route line one unless routed away
  wire route_two   = irq_setup.route_line_two;
  // strap high uses long low pulse on line two
  wire start_long  = boot_event & ~strap_low;
  // strap low pulse only when enabled
  wire start_short = boot_event & strap_low & boot_irq_enable_i;
  wire pulse_start = start_long | start_short;

  wire [TIMER_BITS-1:0] short_len = TIMER_BITS'(SHORT_CYCLES);
  wire [TIMER_BITS-1:0] long_len  = TIMER_BITS'(LONG_CYCLES);
  wire [TIMER_BITS-1:0] pulse_len = start_long ? long_len : short_len;

  wire [7:0] mag_le_low  = vector_magnitude[7:0];
  // high nibble right justified, upper zero
  wire [7:0] mag_le_high = {4'h0, vector_magnitude[11:8]};
  wire [7:0] mag_be_low  = vector_magnitude[11:4];
  wire [7:0] mag_be_high = {vector_magnitude[3:0], 4'h0};
  wire [7:0] mag_low_view  = byte_order_select_i ? mag_be_low : mag_le_low;
  wire [7:0] mag_high_view = byte_order_select_i ? mag_be_high : mag_le_high;

  wire hit_status = (access_i.address == boot_regs_pkg::OFS_BOOT_STATUS);
  wire hit_temp   = (access_i.address == boot_regs_pkg::OFS_TEMP_RESULT);
  wire hit_low    = (access_i.address == boot_regs_pkg::OFS_MAG_LOW);
  wire hit_high   = (access_i.address == boot_regs_pkg::OFS_MAG_HIGH);

  // value passes unscaled, zero means 25 degrees
  wire [7:0] status_view = {7'h00, boot_done_flag};
  wire [7:0] next_read_data = hit_status ? status_view :
                              hit_temp   ? temperature_result :
                              hit_low    ? mag_low_view :
                              hit_high   ? mag_high_view : 8'h00;

  wire next_drdy_clear = read_ok & (hit_low | hit_high);

  wire boot_regs_pkg::irq_setup_t next_irq_setup =
    setup_take ? setup_data_i :
    hibernate_exit_i ? boot_regs_pkg::IRQ_SETUP_RESET : irq_setup;

  // short pulse level from polarity, active high default; long pulse level always low
  wire line_level_on  = pulse_long ? 1'b0 : pulse_pol_high;
  wire line_od        = pulse_long | pulse_open_drain;
  wire line_drive_on  = pulse_active & (line_od ? ~line_level_on : 1'b1);
  wire line_idle_od   = line_od;
  wire line_value     = pulse_active ? line_level_on : ~line_level_on;
  wire line_oe_n      = line_idle_od ? ~line_drive_on : 1'b0;
  wire next_one_val   = pulse_on_two ? 1'b0 : line_value;
  wire next_one_oe_n  = pulse_on_two ? 1'b1 : line_oe_n;
  wire next_two_val   = pulse_on_two ? line_value : 1'b0;
  wire next_two_oe_n  = pulse_on_two ? line_oe_n : 1'b1;

  boot_pulse_timer #(
    .WIDTH_BITS (TIMER_BITS)
  ) u_boot_pulse_timer (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .start_i   (pulse_start),
    .length_i  (pulse_len),
    .active_o  (pulse_active)
  );

  // strap caught after reset release
  logic strap_caught;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_caught <= 1'b0;
      strap_low    <= 1'b1;
    end else if (!strap_caught) begin
      strap_caught <= 1'b1;
      strap_low    <= ~boot_mode_strap_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_done_flag <= 1'b0;
      boot_seen      <= 1'b0;
    end else begin
      boot_done_flag <= flag_clear ? 1'b0 : (boot_done_flag | boot_event);
      boot_seen      <= flag_clear ? 1'b0 : (boot_seen | boot_event);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_setup <= boot_regs_pkg::IRQ_SETUP_RESET;
    end else begin
      irq_setup <= next_irq_setup;
    end
  end

  // pulse shape latched at start
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pulse_long       <= 1'b0;
      pulse_on_two     <= 1'b0;
      pulse_pol_high   <= 1'b1;
      pulse_open_drain <= 1'b0;
    end else if (pulse_start) begin
      pulse_long       <= start_long;
      pulse_on_two     <= start_long | route_two;
      pulse_pol_high   <= irq_setup.polarity_high;
      pulse_open_drain <= irq_setup.open_drain;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      temperature_result <= boot_regs_pkg::TEMP_RESET;
      vector_magnitude   <= boot_regs_pkg::MAG_VALUE_RESET;
    end else if (sample_i.sample_valid) begin
      temperature_result <= sample_i.temperature;
      if (magnitude_calc_enable_i) begin
        vector_magnitude <= sample_i.magnitude;
      end
    end
  end

  // host answers
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      read_data_o        <= 8'h00;
      read_valid_o       <= 1'b0;
      access_refused_o   <= 1'b0;
      data_ready_clear_o <= 1'b0;
      boot_done_flag_o   <= 1'b0;
    end else begin
      read_data_o        <= read_ok ? next_read_data : 8'h00;
      read_valid_o       <= read_ok;
      access_refused_o   <= any_access & ~access_ok;
      data_ready_clear_o <= next_drdy_clear;
      boot_done_flag_o   <= flag_clear ? 1'b0 : (boot_done_flag | boot_event);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_line_one_o      <= 1'b0;
      irq_line_one_oe_n_o <= 1'b0;
      irq_line_two_o      <= 1'b0;
      irq_line_two_oe_n_o <= 1'b1;
    end else begin
      irq_line_one_o      <= next_one_val;
      irq_line_one_oe_n_o <= next_one_oe_n;
      irq_line_two_o      <= next_two_val;
      irq_line_two_oe_n_o <= next_two_oe_n;
    end
  end

endmodule : boot_status_and_output_regs

// File: sim/boot_regs_checker.sv
// port assertions for the boot flag and result register block
// bound from the bench top; sees only the block's ports
module boot_regs_checker (
  // clock and reset
  input wire logic                       clk_sys_i,
  input wire logic                       rstn_i,
  // watched ports
  input wire logic                       soft_reset_i,
  input wire logic                       hibernate_exit_i,
  input wire logic                       boot_finished_i,
  input wire logic                       byte_order_select_i,
  input wire boot_regs_pkg::reg_access_t access_i,
  input wire logic [7:0]                 read_data_o,
  input wire logic                       read_valid_o,
  input wire logic                       access_refused_o,
  input wire logic                       data_ready_clear_o,
  input wire logic                       boot_done_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  wire rd_req   = access_i.read_strobe;
  wire any_req  = access_i.read_strobe | access_i.write_strobe;
  wire hi_addr  = access_i.address == boot_regs_pkg::OFS_MAG_HIGH;
  wire mag_addr = hi_addr | (access_i.address == boot_regs_pkg::OFS_MAG_LOW);
  wire rd_ok    = rd_req & boot_done_flag_o;
  // soft reset and hibernate exit both drop the flag
  wire flag_clear = soft_reset_i | hibernate_exit_i;

  a_flag_needs_boot: assert property ($rose(boot_done_flag_o) |-> $past(boot_finished_i))
    else $error("boot flag rose without boot finishing");
  a_flag_stays_set: assert property (boot_done_flag_o && !flag_clear |=> boot_done_flag_o)
    else $error("boot flag dropped without a clear");
  a_soft_clears: assert property (flag_clear |=> !boot_done_flag_o)
    else $error("flag clear left boot flag set");
  a_refuse_early: assert property (any_req && !boot_done_flag_o |=> access_refused_o && !read_valid_o)
    else $error("access before boot not refused");
  a_read_answered: assert property (rd_ok |=> read_valid_o && !access_refused_o)
    else $error("read after boot not answered");
  a_mag_read_clear: assert property (rd_ok && mag_addr |=> data_ready_clear_o)
    else $error("magnitude read did not clear data ready");
  a_le_upper_zero: assert property (rd_ok && hi_addr && !byte_order_select_i |=> read_data_o[7:4] == 4'h0)
    else $error("little endian upper nibble not zero");
  a_be_lower_zero: assert property (rd_ok && hi_addr && byte_order_select_i |=> read_data_o[3:0] == 4'h0)
    else $error("big endian lower nibble not zero");
endmodule : boot_regs_checker

// File: sim/host_model.sv
// host processor model issuing one register access at a time
// assumes the block answers on the taking edge, read at the next falling edge
module host_model (
  // clock
  input  wire logic                 clk_sys_i,
  // answers
  input  wire logic [7:0]           read_data_o,
  input  wire logic                 read_valid_o,
  input  wire logic                 access_refused_o,
  // request
  output boot_regs_pkg::reg_access_t access_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial access_o = '0;
  // refusal reported, flag zero never assumed
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] wd, input int gap,
                      output logic [7:0] rd, output logic ok);
    repeat (gap + 1) @(negedge clk_sys_i);
    access_o = '{!wr, wr, adr, wd};
    @(negedge clk_sys_i);
    access_o = '{1'b0, 1'b0, ~adr, ~wd};
    rd = read_data_o;
    ok = (wr || read_valid_o === 1'b1) && access_refused_o === 1'b0;
  endtask : xfer
endmodule : host_model

// File: sim/boot_status_and_output_regs_bench.sv
// self-checking bench for the boot flag and result register block
// inputs change on the falling edge; host accesses go through host_model
module boot_status_and_output_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rstn_i = 0, soft_reset_i = 0, hibernate_exit_i = 0, boot_finished_i = 0;
  logic boot_mode_strap_i = 0, boot_irq_enable_i = 1, setup_write_i = 0;
  logic magnitude_calc_enable_i = 0, byte_order_select_i = 0;
  boot_regs_pkg::irq_setup_t     setup_data_i = '0;
  boot_regs_pkg::result_sample_t sample_i = '0;
  boot_regs_pkg::reg_access_t    access_i;
  logic [7:0] read_data_o, rd;
  logic read_valid_o, access_refused_o, data_ready_clear_o, boot_done_flag_o, ok;
  logic irq_line_one_o, irq_line_one_oe_n_o, irq_line_two_o, irq_line_two_oe_n_o;
  int   mismatches = 0, comparisons = 0, n;

  boot_status_and_output_regs #(.SHORT_CYCLES(4), .LONG_CYCLES(20)) dut (.*);
  host_model host (.clk_sys_i, .read_data_o, .read_valid_o, .access_refused_o, .access_o(access_i));

  initial begin
    clk_sys_i = 0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rchk(input string what, input logic [7:0] adr, input logic [7:0] exp);
    host.xfer(1'b0, adr, 8'h00, 0, rd, ok);
    chk(what, exp, rd);
  endtask : rchk

  task automatic give(input logic [7:0] t, input logic [11:0] m);
    @(negedge clk_sys_i);
    sample_i = '{1'b1, t, m};
    @(negedge clk_sys_i);
    sample_i.sample_valid = 1'b0;
  endtask : give

  // counts active cycles: 1 line one driven high, else line two pin low with its pull-up
  task automatic pulse_len(input int which);
    n = 0;
    @(negedge clk_sys_i);
    boot_finished_i = 1'b1;
    repeat (40) begin
      @(negedge clk_sys_i);
      case (which)
        1: n += int'(irq_line_one_o === 1'b1 && irq_line_one_oe_n_o === 1'b0);
        default: n += int'((irq_line_two_oe_n_o === 1'b1 ? 1'b1 : irq_line_two_o) === 1'b0);
      endcase
    end
  endtask : pulse_len

  task automatic t_boot();
    host.xfer(1'b0, boot_regs_pkg::OFS_BOOT_STATUS, 8'h00, 3, rd, ok);
    chk("early read accepted", 8'h00, {7'h00, ok});
    @(negedge clk_sys_i);
    setup_data_i = '{1'b0, 1'b0, 1'b1};
    setup_write_i = 1'b1;
    @(negedge clk_sys_i);
    setup_write_i = 1'b0;
    pulse_len(1);
    chk("line one pulse", 8'h04, 8'(n));
    chk("boot flag", 8'h01, {7'h00, boot_done_flag_o});
    host.xfer(1'b0, boot_regs_pkg::OFS_BOOT_STATUS, 8'h00, 0, rd, ok);
    chk("status bit", 8'h01, {7'h00, rd[0] & ok});
    $display("test boot done");
  endtask : t_boot

  task automatic t_temp();
    give(8'hE7, 12'h000);
    rchk("temperature", boot_regs_pkg::OFS_TEMP_RESULT, 8'hE7);
    chk("no clear on temperature read", 8'h00, {7'h00, data_ready_clear_o});
    host.xfer(1'b1, boot_regs_pkg::OFS_TEMP_RESULT, 8'h55, 0, rd, ok);
    rchk("temperature kept", boot_regs_pkg::OFS_TEMP_RESULT, 8'hE7);
    give(8'h00, 12'h000);
    rchk("temperature zero", boot_regs_pkg::OFS_TEMP_RESULT, 8'h00);
    $display("test temperature done");
  endtask : t_temp

  task automatic t_mag();
    rchk("magnitude low reset", boot_regs_pkg::OFS_MAG_LOW, 8'h00);
    rchk("magnitude high reset", boot_regs_pkg::OFS_MAG_HIGH, 8'h00);
    magnitude_calc_enable_i = 1'b1;
    give(8'h10, 12'hABC);
    rchk("le low", boot_regs_pkg::OFS_MAG_LOW, 8'hBC);
    chk("clear on low read", 8'h01, {7'h00, data_ready_clear_o});
    rchk("le high", boot_regs_pkg::OFS_MAG_HIGH, 8'h0A);
    chk("clear on high read", 8'h01, {7'h00, data_ready_clear_o});
    byte_order_select_i = 1'b1;
    rchk("be low", boot_regs_pkg::OFS_MAG_LOW, 8'hAB);
    rchk("be high", boot_regs_pkg::OFS_MAG_HIGH, 8'hC0);
    magnitude_calc_enable_i = 1'b0;
    byte_order_select_i = 1'b0;
    give(8'h10, 12'h123);
    rchk("magnitude held", boot_regs_pkg::OFS_MAG_LOW, 8'hBC);
    $display("test magnitude done");
  endtask : t_mag

  task automatic t_soft();
    @(negedge clk_sys_i);
    // active low push-pull, routed to line two
    setup_data_i = '{1'b0, 1'b0, 1'b1};
    setup_write_i = 1'b1;
    @(negedge clk_sys_i);
    setup_write_i = 1'b0;
    soft_reset_i = 1'b1;
    boot_finished_i = 1'b0;
    @(negedge clk_sys_i);
    soft_reset_i = 1'b0;
    chk("flag after soft reset", 8'h00, {7'h00, boot_done_flag_o});
    pulse_len(3);
    chk("line two pulse", 8'h04, 8'(n));
    $display("test soft reset done");
  endtask : t_soft

  task automatic t_quiet();
    @(negedge clk_sys_i);
    soft_reset_i = 1'b1;
    boot_finished_i = 1'b0;
    boot_irq_enable_i = 1'b0;
    @(negedge clk_sys_i);
    soft_reset_i = 1'b0;
    host.xfer(1'b0, boot_regs_pkg::OFS_TEMP_RESULT, 8'h00, 0, rd, ok);
    chk("read after soft reset", 8'h00, {7'h00, ok});
    pulse_len(3);
    chk("disabled boot pulse", 8'h00, 8'(n));
    chk("flag without pulse", 8'h01, {7'h00, boot_done_flag_o});
    boot_irq_enable_i = 1'b1;
    $display("test boot interrupt off done");
  endtask : t_quiet

  task automatic t_hib();
    @(negedge clk_sys_i);
    hibernate_exit_i = 1'b1;
    boot_finished_i = 1'b0;
    @(negedge clk_sys_i);
    hibernate_exit_i = 1'b0;
    chk("flag after hibernate exit", 8'h00, {7'h00, boot_done_flag_o});
    pulse_len(1);
    chk("default pulse after hibernate", 8'h04, 8'(n));
    $display("test hibernate exit done");
  endtask : t_hib

  task automatic t_strap();
    rstn_i = 1'b0;
    boot_finished_i = 1'b0;
    boot_mode_strap_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    pulse_len(3);
    chk("long low pulse", 8'h14, 8'(n));
    $display("test strap high done");
  endtask : t_strap

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  initial begin
    #100us;
    mismatches++;
    conclude();
  end

  initial begin
    repeat (5) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    t_boot();
    t_temp();
    t_mag();
    t_soft();
    t_quiet();
    t_hib();
    t_strap();
    conclude();
  end
endmodule : boot_status_and_output_regs_bench

bind boot_status_and_output_regs boot_regs_checker chk_i (.*);
